// ### design/mul_branch_pkg.sv
// Package: opcodes, decode record, flags and register map of the decoder
package mul_branch_pkg;

  // Whole-word opcodes
  localparam logic [15:0] CODE_ADD_PRODUCT   = 16'hce15;
  localparam logic [15:0] CODE_LOAD_PRODUCT  = 16'hce14;
  localparam logic [15:0] CODE_SUB_PRODUCT   = 16'hce16;
  localparam logic [15:0] CODE_BRANCH_ACC    = 16'hce25;
  localparam logic [15:0] CODE_BRANCH_ALWAYS = 16'hff80;
  localparam logic [15:0] CODE_SHIFT_BASE    = 16'hce08;
  localparam logic [15:0] CODE_SHIFT_MASK    = 16'hfffc;

  // Upper-byte opcodes
  localparam logic [7:0] UB_LOAD_P_UPPER  = 8'h53;
  localparam logic [7:0] UB_LOAD_T        = 8'h3c;
  localparam logic [7:0] UB_LOAD_T_ACC    = 8'h3d;
  localparam logic [7:0] UB_LOAD_T_MOVE   = 8'h3f;
  localparam logic [7:0] UB_LOAD_T_P2ACC  = 8'h3e;
  localparam logic [7:0] UB_LOAD_T_SUB    = 8'h5b;
  localparam logic [7:0] UB_MAC           = 8'h5d;
  localparam logic [7:0] UB_MAC_MOVE      = 8'h5c;
  localparam logic [7:0] UB_MULT          = 8'h38;
  localparam logic [7:0] UB_MULT_ADD      = 8'h3a;
  localparam logic [7:0] UB_MULT_SUB      = 8'h3b;
  localparam logic [7:0] UB_MULT_UNSIGNED = 8'hcf;
  localparam logic [7:0] UB_SQUARE_ACC    = 8'h39;
  localparam logic [7:0] UB_SQUARE_SUB    = 8'h5a;
  localparam logic [7:0] UB_STORE_UPPER   = 8'h7d;
  localparam logic [7:0] UB_STORE_LOWER   = 8'h7c;
  localparam logic [7:0] UB_BR_AUX        = 8'hfb;
  localparam logic [7:0] UB_BR_TEST_SET   = 8'hf9;
  localparam logic [7:0] UB_BR_TEST_CLR   = 8'hf8;
  localparam logic [7:0] UB_BR_NONNEG     = 8'hf4;
  localparam logic [7:0] UB_BR_POSITIVE   = 8'hf1;
  localparam logic [7:0] UB_BR_CARRY      = 8'h5e;
  localparam logic [2:0] TOP_MULT_CONST   = 3'h5;
  localparam int         ADDR_MODE_BIT    = 7;

  // Register map and reset values
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_PC     = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] PC_STEP    = 16'h0001;

  typedef enum logic [4:0] {
    op_none, add_product_to_acc, load_acc_from_product, sub_product_from_acc,
    load_product_upper, load_multiplicand, load_multiplicand_accumulate,
    load_multiplicand_acc_move, load_multiplicand_product_to_acc,
    load_multiplicand_subtract, multiply_accumulate, multiply_accumulate_move,
    multiply_op, multiply_add_prior, multiply_sub_prior, multiply_by_constant,
    multiply_without_sign, store_product_upper, store_product_lower,
    set_product_shift, square_accumulate, square_subtract,
    branch_always, branch_via_acc, branch_aux_nonzero, branch_test_flag_set,
    branch_test_flag_clear, branch_on_carry_set, branch_acc_nonnegative,
    branch_acc_positive
  } op_e;

  typedef enum logic [0:0] {
    st_first  = 1'h0,
    st_second = 1'h1
  } state_e;

  typedef struct packed {
    op_e         op;
    logic        indirect;
    logic [6:0]  operand;
    logic [12:0] konst;
    logic [1:0]  product_shift_field;
    logic [15:0] second_word;
    logic        two_word;
  } decode_s;

  typedef struct packed {
    logic [31:0] acc;
    logic        test_control_flag;
    logic        carry;
    logic        aux_nonzero;
  } flags_s;

endpackage

// ### design/opcode_classify.sv
// Combinational opcode classifier for one instruction word
`timescale 1ns/1ps
`default_nettype none
module opcode_classify
  import mul_branch_pkg::*;
(
  input  wire logic [15:0] word,
  output op_e              op,
  output logic             two_word
);

  // Whole-word codes first, then immediate multiply, then upper byte
  always_comb begin
    op = op_none;
    if (word == CODE_ADD_PRODUCT) begin
      op = add_product_to_acc;
    end else if (word == CODE_LOAD_PRODUCT) begin
      op = load_acc_from_product;
    end else if (word == CODE_SUB_PRODUCT) begin
      op = sub_product_from_acc;
    end else if ((word & CODE_SHIFT_MASK) == CODE_SHIFT_BASE) begin
      op = set_product_shift;
    end else if (word == CODE_BRANCH_ACC) begin
      op = branch_via_acc;
    end else if (word == CODE_BRANCH_ALWAYS) begin
      op = branch_always;
    end else if (word[15:13] == TOP_MULT_CONST) begin
      op = multiply_by_constant;
    end else begin
      case (word[15:8])
        UB_LOAD_P_UPPER:  op = load_product_upper;
        UB_LOAD_T:        op = load_multiplicand;
        UB_LOAD_T_ACC:    op = load_multiplicand_accumulate;
        UB_LOAD_T_MOVE:   op = load_multiplicand_acc_move;
        UB_LOAD_T_P2ACC:  op = load_multiplicand_product_to_acc;
        UB_LOAD_T_SUB:    op = load_multiplicand_subtract;
        UB_MAC:           op = multiply_accumulate;
        UB_MAC_MOVE:      op = multiply_accumulate_move;
        UB_MULT:          op = multiply_op;
        UB_MULT_ADD:      op = multiply_add_prior;
        UB_MULT_SUB:      op = multiply_sub_prior;
        UB_MULT_UNSIGNED: op = multiply_without_sign;
        UB_SQUARE_ACC:    op = square_accumulate;
        UB_SQUARE_SUB:    op = square_subtract;
        UB_STORE_UPPER:   op = store_product_upper;
        UB_STORE_LOWER:   op = store_product_lower;
        UB_BR_TEST_SET:   op = branch_test_flag_set;
        UB_BR_TEST_CLR:   op = branch_test_flag_clear;
        UB_BR_NONNEG:     op = branch_acc_nonnegative;
        UB_BR_POSITIVE:   op = branch_acc_positive;
        UB_BR_AUX: begin
          if (word[ADDR_MODE_BIT]) begin
            op = branch_aux_nonzero;
          end
        end
        UB_BR_CARRY: begin
          if (word[ADDR_MODE_BIT]) begin
            op = branch_on_carry_set;
          end
        end
        default:          op = op_none;
      endcase
    end
  end

  // Multiply-accumulate forms and all but the indirect branch take two words
  always_comb begin
    case (op)
      multiply_accumulate, multiply_accumulate_move, branch_always,
      branch_aux_nonzero, branch_test_flag_set, branch_test_flag_clear,
      branch_on_carry_set, branch_acc_nonnegative,
      branch_acc_positive: two_word = 1'h1;
      default:             two_word = 1'h0;
    endcase
  end

endmodule
`default_nettype wire

// ### design/mul_branch_opcode_decoder.sv
// Multiply and branch instruction decoder with program counter
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Whole words ce15, ce14, ce16 add, load, subtract product with acc.
// - Upper byte 53 loads product upper half; bit 7 mode, bits 6-0 operand.
// - Upper bytes 3c, 3d, 3f are three of the five multiplicand loads.
// - Upper byte 3e loads multiplicand and moves product to acc.
// - Upper byte 5b loads multiplicand and subtracts prior product.
// - Upper bytes 5d, 5c are two-word multiply-accumulate, 5c with move.
// - Upper byte 38 multiplies multiplicand by data operand into product.
// - Upper bytes 3a, 3b multiply and add or subtract prior product.
// - Upper bytes 39, 5a square and accumulate or subtract.
// - Upper bytes 7d, 7c store product upper or lower half.
// - Words ce08 to ce0b load the two-bit product shift field.
// - Word ce25 branches to the address held in the accumulator.
// - Upper byte fb with bit 7 branches when aux register nonzero.
// - Upper bytes f9, f8 branch on test flag set or clear.
// - Upper bytes f4, f1 branch on acc nonnegative or positive.
// - Word ff80 always branches; 5e with bit 7 branches on carry.
module mul_branch_opcode_decoder
  import mul_branch_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        word_valid,
  input  wire logic [15:0] word_data,
  output logic             word_ready,
  input  wire flags_s      flags,
  output logic             dec_valid,
  output decode_s          dec,
  output logic             branch_taken,
  output logic [15:0]      pc,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);

  state_e      st_r;
  state_e      st_nxt;
  decode_s     pend_r;
  decode_s     pend_nxt;
  decode_s     dec_r;
  decode_s     dec_nxt;
  logic        dec_valid_r;
  logic        dec_valid_nxt;
  logic        taken_r;
  logic        taken_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  op_e         cls_op;
  logic        cls_two;
  decode_s     first_dec;
  logic        pc_load;
  logic        take_word;
  logic        cond_met;

  opcode_classify u_classify (
    .word     (word_data),
    .op       (cls_op),
    .two_word (cls_two)
  );

  // Software can pause fetch by clearing the enable bit
  assign word_ready = ctrl_r[0];
  assign pc_load    = reg_wr && (reg_addr == REG_PC);
  assign take_word  = word_valid && word_ready && !pc_load;

  // Fields of the first word
  always_comb begin
    first_dec                     = '0;
    first_dec.op                  = cls_op;
    first_dec.indirect            = word_data[ADDR_MODE_BIT];
    first_dec.operand             = word_data[6:0];
    first_dec.konst               = word_data[12:0];
    first_dec.product_shift_field = word_data[1:0];
    first_dec.two_word            = cls_two;
  end

  // Branch condition on the flags seen with the second word
  always_comb begin
    case (pend_r.op)
      branch_always:          cond_met = 1'h1;
      branch_aux_nonzero:     cond_met = flags.aux_nonzero;
      branch_test_flag_set:   cond_met = flags.test_control_flag;
      branch_test_flag_clear: cond_met = !flags.test_control_flag;
      branch_on_carry_set:    cond_met = flags.carry;
      branch_acc_nonnegative: cond_met = !flags.acc[31];
      branch_acc_positive:    cond_met = !flags.acc[31] && (flags.acc != '0);
      default:                cond_met = 1'h0;
    endcase
  end

  // Decode sequence and program counter, next values
  always_comb begin
    st_nxt        = st_r;
    pend_nxt      = pend_r;
    dec_nxt       = dec_r;
    dec_valid_nxt = 1'h0;
    taken_nxt     = taken_r;
    pc_nxt        = pc_r;
    if (pc_load) begin
      pc_nxt = reg_wdata[15:0];
    end else if (take_word) begin
      case (st_r)
        st_first: begin
          if (cls_two) begin
            pend_nxt = first_dec;
            st_nxt   = st_second;
            pc_nxt   = pc_r + PC_STEP;
          end else begin
            dec_nxt       = first_dec;
            dec_valid_nxt = 1'h1;
            taken_nxt     = (cls_op == branch_via_acc);
            if (cls_op == branch_via_acc) begin
              pc_nxt = flags.acc[15:0];
            end else begin
              pc_nxt = pc_r + PC_STEP;
            end
          end
        end
        st_second: begin
          dec_nxt             = pend_r;
          dec_nxt.second_word = word_data;
          dec_valid_nxt       = 1'h1;
          taken_nxt           = cond_met;
          st_nxt              = st_first;
          if (cond_met) begin
            pc_nxt = word_data;
          end else begin
            pc_nxt = pc_r + PC_STEP;
          end
        end
        default: st_nxt = st_first;
      endcase
    end
  end

  // Decode sequence and program counter, registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r        <= st_first;
      pend_r      <= '0;
      dec_r       <= '0;
      dec_valid_r <= 1'h0;
      taken_r     <= 1'h0;
      pc_r        <= PC_RESET;
    end else begin
      st_r        <= st_nxt;
      pend_r      <= pend_nxt;
      dec_r       <= dec_nxt;
      dec_valid_r <= dec_valid_nxt;
      taken_r     <= taken_nxt;
      pc_r        <= pc_nxt;
    end
  end

  assign dec_valid    = dec_valid_r;
  assign dec          = dec_r;
  assign branch_taken = taken_r;
  assign pc           = pc_r;

  // Register port, next values; unmapped reads return zero
  always_comb begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = '0;
    if (reg_wr && (reg_addr == REG_CTRL)) begin
      ctrl_nxt = {31'h0, reg_wdata[0]};
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   rdata_nxt = ctrl_r;
        REG_STATUS: rdata_nxt = {22'h0, taken_r, st_r, 3'h0, dec_r.op};
        REG_PC:     rdata_nxt = {16'h0, pc_r};
        default:    rdata_nxt = '0;
      endcase
    end
  end

  // Register port, registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r  <= CTRL_RESET;
      rdata_r <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Checks on the decoded output
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_product_acc;
    take_word && (st_r == st_first) && (word_data == CODE_ADD_PRODUCT)
      |=> dec_valid && (dec.op == add_product_to_acc) && !branch_taken;
  endproperty
  a_product_acc: assert property (p_product_acc)
    else $error("product add opcode not decoded");

  property p_upper_load;
    take_word && (st_r == st_first) && (word_data[15:8] == UB_LOAD_P_UPPER)
      |=> (dec.op == load_product_upper)
          && (dec.indirect == $past(word_data[7]))
          && (dec.operand == $past(word_data[6:0]));
  endproperty
  a_upper_load: assert property (p_upper_load)
    else $error("product upper load fields wrong");

  property p_two_word_wait;
    take_word && (st_r == st_first) && (word_data[15:8] == UB_MAC)
      |=> (st_r == st_second) && !dec_valid;
  endproperty
  a_two_word_wait: assert property (p_two_word_wait)
    else $error("two-word multiply did not wait for second word");

  property p_shift_field;
    take_word && (st_r == st_first)
      && ((word_data & CODE_SHIFT_MASK) == CODE_SHIFT_BASE)
      |=> (dec.op == set_product_shift)
          && (dec.product_shift_field == $past(word_data[1:0]));
  endproperty
  a_shift_field: assert property (p_shift_field)
    else $error("product shift field not loaded");

  property p_const_mult;
    take_word && (st_r == st_first) && (word_data[15:13] == TOP_MULT_CONST)
      |=> (dec.op == multiply_by_constant)
          && (dec.konst == $past(word_data[12:0]));
  endproperty
  a_const_mult: assert property (p_const_mult)
    else $error("immediate multiply constant wrong");

  property p_acc_branch;
    take_word && (st_r == st_first) && (word_data == CODE_BRANCH_ACC)
      |=> branch_taken && (pc == $past(flags.acc[15:0]));
  endproperty
  a_acc_branch: assert property (p_acc_branch)
    else $error("accumulator branch target wrong");

  property p_aux_branch;
    take_word && (st_r == st_second) && (pend_r.op == branch_aux_nonzero)
      |=> (branch_taken == $past(flags.aux_nonzero));
  endproperty
  a_aux_branch: assert property (p_aux_branch)
    else $error("aux nonzero branch decision wrong");

  property p_positive_zero;
    take_word && (st_r == st_second) && (pend_r.op == branch_acc_positive)
      && (flags.acc == '0) |=> !branch_taken;
  endproperty
  a_positive_zero: assert property (p_positive_zero)
    else $error("positive branch taken on zero accumulator");

  property p_skip_both;
    (st_r == st_first) ##1 (take_word && (st_r == st_second) && !cond_met)
      |=> (pc == $past(pc, 2) + PC_STEP + PC_STEP) && !branch_taken;
  endproperty
  a_skip_both: assert property (p_skip_both)
    else $error("untaken branch did not skip both words");

  property p_target_taken;
    take_word && (st_r == st_second) && cond_met
      |=> (pc == $past(word_data)) && (dec.second_word == $past(word_data));
  endproperty
  a_target_taken: assert property (p_target_taken)
    else $error("taken branch target wrong");

  property p_load_mult;
    take_word && (st_r == st_first) && (word_data[15:8] == UB_LOAD_T)
      |=> dec_valid && (dec.op == load_multiplicand) && !dec.two_word;
  endproperty
  a_load_mult: assert property (p_load_mult)
    else $error("multiplicand load not decoded");

  property p_mult_prior;
    take_word && (st_r == st_first) && (word_data[15:8] == UB_MULT_ADD)
      |=> (dec.op == multiply_add_prior)
          && (dec.indirect == $past(word_data[7]));
  endproperty
  a_mult_prior: assert property (p_mult_prior)
    else $error("multiply with prior add fields wrong");

  property p_test_clear;
    take_word && (st_r == st_second) && (pend_r.op == branch_test_flag_clear)
      |=> (branch_taken == !$past(flags.test_control_flag));
  endproperty
  a_test_clear: assert property (p_test_clear)
    else $error("test flag clear branch decision wrong");

  property p_carry_mode;
    take_word && (st_r == st_first) && (word_data[15:8] == UB_BR_CARRY)
      && !word_data[ADDR_MODE_BIT] |=> dec_valid && (dec.op == op_none);
  endproperty
  a_carry_mode: assert property (p_carry_mode)
    else $error("carry branch decoded without mode bit");

  c_taken_branch: cover property (dec_valid && branch_taken && dec.two_word);
  c_untaken:      cover property (dec_valid && !branch_taken && dec.two_word);
  c_mac:          cover property (dec_valid && dec.op == multiply_accumulate);
  c_stall:        cover property (word_valid && !word_ready);

endmodule
`default_nettype wire

// ### bench/fetch_model.sv
// Fetch-side partner: offers queued instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        word_ready,
  input  wire logic        pc_wr,
  input  wire logic        slow,
  output logic             word_valid,
  output logic [15:0]      word_data
);
  logic [15:0] q[$];
  logic        taken;

  // Bench loads words here, off the clock edge
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask

  // A word offered beside a PC write is not taken
  assign taken = word_valid && word_ready && !pc_wr;

  // Offer held until taken; idle data toggles every cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_valid <= 1'b0;
      word_data  <= 16'h0000;
    end else if (!word_valid || taken) begin
      if (taken) void'(q.pop_front());
      if (q.size() != 0 && (!slow || $urandom_range(1) == 1)) begin
        word_valid <= 1'b1;
        word_data  <= q[0];
      end else begin
        word_valid <= 1'b0;
        word_data  <= ~word_data;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the multiply and branch decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import mul_branch_pkg::*;
  typedef struct {
    op_e op; logic tk; logic two; logic [15:0] pc; logic [15:0] sw;
    logic [15:0] w; int kind;
  } exp_s;
  localparam logic [7:0] MUL_UB [16] = '{UB_LOAD_P_UPPER, UB_LOAD_T,
    UB_LOAD_T_ACC, UB_LOAD_T_MOVE, UB_LOAD_T_P2ACC, UB_LOAD_T_SUB, UB_MAC,
    UB_MAC_MOVE, UB_MULT, UB_MULT_ADD, UB_MULT_SUB, UB_MULT_UNSIGNED,
    UB_SQUARE_ACC, UB_SQUARE_SUB, UB_STORE_UPPER, UB_STORE_LOWER};
  logic        clk, rstn, word_valid, word_ready, dec_valid, branch_taken;
  logic        reg_wr, reg_rd, slow, pc_wr;
  logic [15:0] word_data, pc, exp_pc;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  flags_s      flags;
  decode_s     dec;
  exp_s        expq[$];
  exp_s        me;
  int          num_errors, n_checks;

  mul_branch_opcode_decoder dut_u (.clk(clk), .rstn(rstn),
    .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
    .flags(flags), .dec_valid(dec_valid), .dec(dec),
    .branch_taken(branch_taken), .pc(pc), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  fetch_model fetch_u (.clk(clk), .rstn(rstn), .word_ready(word_ready),
    .pc_wr(pc_wr), .slow(slow), .word_valid(word_valid),
    .word_data(word_data));
  assign pc_wr = reg_wr && (reg_addr == REG_PC);

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reference decode of the first word
  function automatic op_e ref_op(input logic [15:0] w);
    if (w == 16'hce15) return add_product_to_acc;
    if (w == 16'hce14) return load_acc_from_product;
    if (w == 16'hce16) return sub_product_from_acc;
    if (w == 16'hce25) return branch_via_acc;
    if (w == 16'hff80) return branch_always;
    if (w[15:2] == 14'h3382) return set_product_shift;
    if (w[15:13] == 3'b101) return multiply_by_constant;
    case (w[15:8])
      8'h53: return load_product_upper;
      8'h3c: return load_multiplicand;
      8'h3d: return load_multiplicand_accumulate;
      8'h3f: return load_multiplicand_acc_move;
      8'h3e: return load_multiplicand_product_to_acc;
      8'h5b: return load_multiplicand_subtract;
      8'h5d: return multiply_accumulate;
      8'h5c: return multiply_accumulate_move;
      8'h38: return multiply_op;
      8'h3a: return multiply_add_prior;
      8'h3b: return multiply_sub_prior;
      8'hcf: return multiply_without_sign;
      8'h39: return square_accumulate;
      8'h5a: return square_subtract;
      8'h7d: return store_product_upper;
      8'h7c: return store_product_lower;
      8'hfb: return w[7] ? branch_aux_nonzero : op_none;
      8'h5e: return w[7] ? branch_on_carry_set : op_none;
      8'hf9: return branch_test_flag_set;
      8'hf8: return branch_test_flag_clear;
      8'hf4: return branch_acc_nonnegative;
      8'hf1: return branch_acc_positive;
      default: return op_none;
    endcase
  endfunction

  // Queue one instruction and note its expected outcome
  task automatic send(input logic [15:0] w, input logic [15:0] sw,
                      input int kind);
    exp_s e;
    e.op = ref_op(w);
    e.w = w;
    e.sw = sw;
    e.kind = kind;
    e.two = e.op inside {multiply_accumulate, multiply_accumulate_move,
      branch_always, branch_aux_nonzero, branch_test_flag_set,
      branch_test_flag_clear, branch_on_carry_set, branch_acc_nonnegative,
      branch_acc_positive};
    case (e.op)
      branch_always, branch_via_acc: e.tk = 1'b1;
      branch_aux_nonzero:     e.tk = flags.aux_nonzero;
      branch_test_flag_set:   e.tk = flags.test_control_flag;
      branch_test_flag_clear: e.tk = !flags.test_control_flag;
      branch_on_carry_set:    e.tk = flags.carry;
      branch_acc_nonnegative: e.tk = !flags.acc[31];
      branch_acc_positive:    e.tk = !flags.acc[31] && flags.acc != 0;
      default:                e.tk = 1'b0;
    endcase
    if (e.op == branch_via_acc) exp_pc = flags.acc[15:0];
    else if (e.tk) exp_pc = sw;
    else exp_pc = exp_pc + (e.two ? 16'h0002 : 16'h0001);
    e.pc = exp_pc;
    fetch_u.push(w);
    if (e.two) fetch_u.push(sw);
    expq.push_back(e);
  endtask

  // Register port accesses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, x)
  endtask

  // Wait until every queued word has been decoded
  task automatic drain();
    int n;
    n = 0;
    while ((fetch_u.q.size() != 0 || expq.size() != 0) && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < 300, 1'b1)
    repeat (2) @(posedge clk);
  endtask

  // Multiply group, back to back, random operand fields
  task automatic mul_batch();
    logic [15:0] r;
    @(posedge clk);
    slow <= $urandom_range(1);
    @(negedge clk);
    send(CODE_ADD_PRODUCT, 16'h0000, 0);
    send(CODE_LOAD_PRODUCT, 16'h0000, 0);
    send(CODE_SUB_PRODUCT, 16'h0000, 0);
    for (int i = 0; i < 16; i++) begin
      r = 16'($urandom);
      send({MUL_UB[i], r[7:0]}, ~r, 1);
    end
    for (int j = 0; j < 4; j++) send(CODE_SHIFT_BASE | 16'(j), 16'h0000, 3);
    r = 16'($urandom);
    send({TOP_MULT_CONST, r[12:0]}, 16'h0000, 2);
  endtask

  // Branch group under one set of flags
  task automatic br_batch(input flags_s f);
    logic [15:0] r;
    @(posedge clk);
    flags <= f;
    slow <= $urandom_range(1);
    @(negedge clk);
    r = 16'($urandom);
    send(CODE_BRANCH_ALWAYS, r, 0);
    send(CODE_BRANCH_ACC, 16'h0000, 0);
    send({UB_BR_AUX, 1'b1, r[6:0]}, ~r, 0);
    send({UB_BR_AUX, 1'b0, r[6:0]}, 16'h0000, 0);
    send({UB_BR_TEST_SET, r[7:0]}, r ^ 16'h00ff, 0);
    send({UB_BR_TEST_CLR, r[15:8]}, r ^ 16'h0f0f, 0);
    send({UB_BR_NONNEG, r[7:0]}, r ^ 16'hf000, 0);
    send({UB_BR_POSITIVE, r[7:0]}, r ^ 16'h3333, 0);
    send({UB_BR_CARRY, 1'b1, r[6:0]}, r ^ 16'h5555, 0);
    send({UB_BR_CARRY, 1'b0, r[6:0]}, 16'h0000, 0);
    drain();
  endtask

  // Result watcher: oldest note against each decoded instruction
  always @(posedge clk) begin
    #1;
    if (dec_valid === 1'b1) begin
      if (expq.size() == 0) `CHK(dec_valid, 1'b0)
      else begin
        me = expq.pop_front();
        `CHK(dec.op, me.op)
        `CHK(dec.two_word, me.two)
        `CHK(branch_taken, me.tk)
        `CHK(pc, me.pc)
        if (me.two) `CHK(dec.second_word, me.sw)
        if (me.kind == 1) `CHK(dec.indirect, me.w[7])
        if (me.kind == 1) `CHK(dec.operand, me.w[6:0])
        if (me.kind == 2) `CHK(dec.konst, me.w[12:0])
        if (me.kind == 3) `CHK(dec.product_shift_field, me.w[1:0])
      end
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog
  initial begin
    #100us;
    num_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slow = 1'b0;
    flags = '0;
    exp_pc = PC_RESET;
    num_errors = 0;
    n_checks = 0;
    void'($urandom(59688));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_PC, {16'h0000, PC_RESET});
    rd(REG_STATUS, 32'h0000_0000);
    rd(8'h0c, 32'h0000_0000);
    mul_batch();
    drain();
    rd(REG_STATUS, {27'h0, multiply_by_constant});
    rd(REG_PC, {16'h0000, exp_pc});
    br_batch('{acc: 32'h0, test_control_flag: 1'b1, carry: 1'b0,
               aux_nonzero: 1'b1});
    br_batch('{acc: 32'h8000_0000 | $urandom, test_control_flag: 1'b0,
               carry: 1'b1, aux_nonzero: 1'b0});
    br_batch('{acc: 32'h7fff_ffff & $urandom, test_control_flag: 1'b1,
               carry: 1'b1, aux_nonzero: 1'b1});
    // Halted fetch keeps the word waiting, then resumes at the new PC
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_PC, 32'h0000_0100);
    exp_pc = 16'h0100;
    @(negedge clk);
    send(CODE_ADD_PRODUCT, 16'h0000, 0);
    repeat (6) @(posedge clk);
    #1 `CHK(word_ready, 1'b0)
    `CHK(expq.size(), 1)
    wr(REG_CTRL, 32'h0000_0001);
    drain();
    rd(REG_PC, 32'h0000_0101);
    complete_run();
  end
endmodule
`default_nettype wire
